// [rtl/cis_sequencer.sv]
// Interrupt and reset vectoring sequencer of the 8-bit core
//
// Function
// - Reset and each source own a vector
// - Lower vector address wins; reset first
// - Serve only when individual and global enabled
// - Table select bit moves vectors to boot
// - Boot reset fuse moves reset vector
// - Boot locks may mute interrupts by PC
// - Accepting an interrupt clears global enable
// - Re-enabled global enable allows nesting
// - Return sets global enable
// - Hardware clears flag when vectoring
// - Writing one clears flag, zero keeps
// - Disabled flags stay latched, served by priority
// - Level sources request only while present
// - One main instruction runs after return
// - Global disable acts at once
// - Instruction after global enable runs first
// - Entry takes four cycles, pushes counter
// - Multi-cycle instruction finishes before service
// - Wake from sleep adds four cycles
// - Return takes four cycles, pops, SP plus two
// - Saved program counter is 13 bits
// - Push lowers stack pointer by two
// - Global enable is status bit 7
`timescale 1ns/1ps
module cis_sequencer (
  input wire logic clk_sys, // Core clock, 200 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire cis_pkg::cis_core_t core, // Boundary report from core
  input wire cis_pkg::cis_lock_t lock, // Vector and lock setup
  input wire logic [cis_pkg::N_FLAG-1:0] flag_event, // Flag events
  input wire logic flag_clear_wr, // Flag clear strobe
  input wire logic [cis_pkg::N_FLAG-1:0] flag_clear_data, // Ones clear
  input wire logic [cis_pkg::N_LVL-1:0] level_req, // Level sources
  input wire logic [cis_pkg::N_SRC-1:0] irq_enable, // Per source
  input wire logic status_wr, // Status byte write
  input wire logic [cis_pkg::BYTE_W-1:0] status_wdata, // Its data
  input wire logic sp_wr, // Stack pointer write
  input wire logic [cis_pkg::SP_W-1:0] sp_wdata, // Its data
  input wire logic [cis_pkg::BYTE_W-1:0] stk_rdata, // Read data
  output cis_pkg::cis_stack_t stk, // Stack access
  output logic core_hold, // Stall the core
  output logic pc_load, // Load program counter
  output logic [cis_pkg::PC_W-1:0] pc_value, // New program counter
  output logic global_enable, // Status bit of global enable
  output logic [cis_pkg::SP_W-1:0] sp_value, // Stack pointer
  output logic serve_pulse, // Entry accepted
  output logic [cis_pkg::IDX_W-1:0] serve_idx, // Source accepted
  output logic [cis_pkg::N_FLAG-1:0] flags // Latched flags
);
  import cis_pkg::*;

  typedef struct packed {
    cis_state_t fsm;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] last;
    logic gie;
    logic [SP_W-1:0] sp;
    logic [PC_W-1:0] ret_pc;
    logic [PC_W-1:0] vec;
    logic hold;
    logic pc_load;
    logic [PC_W-1:0] pc_val;
    logic serve;
    logic [IDX_W-1:0] idx;
    cis_stack_t stk;
  } cis_seq_st_t;

  cis_seq_st_t st_reg;
  cis_seq_st_t st_next;
  logic win_valid;
  logic [IDX_W-1:0] win_idx;
  logic take;
  logic start_ret;
  logic [PC_W-1:0] table_base;
  logic [PC_W-1:0] vec_addr;

  cis_flag_bank u_flags (
    .clk_sys(clk_sys),
    .srst(srst),
    .event_in(flag_event),
    .clr_wr(flag_clear_wr),
    .clr_data(flag_clear_data),
    .hw_ack(take),
    .hw_idx(win_idx),
    .flags(flags)
  );

  cis_arbiter u_arb (
    .flags(flags),
    .level_req(level_req),
    .enables(irq_enable),
    .pc(core.next_pc),
    .lock(lock),
    .win_valid(win_valid),
    .win_idx(win_idx)
  );

  // Decision only at a finished instruction, never mid-sequence
  assign take = (st_reg.fsm == CIS_IDLE) && core.boundary &&
    win_valid && st_reg.gie &&
    !core.op_cli &&
    !core.op_sei &&
    !core.op_return;
  assign start_ret = (st_reg.fsm == CIS_IDLE) && core.boundary &&
    core.op_return;

  // Vector word: table base plus slot, slot 0 being reset
  assign table_base = lock.vector_table_select ? BOOT_START :
    APP_START;
  assign vec_addr = table_base +
    (PC_W'(win_idx) + 13'h0001) * VEC_STRIDE;

  // Next-state of the sequencer; pulses default low each cycle
  always_comb begin
    st_next = st_reg;
    st_next.pc_load = 1'b0;
    st_next.serve = 1'b0;
    st_next.stk.wr_en = 1'b0;
    st_next.stk.rd_en = 1'b0;
    unique case (st_reg.fsm)
      CIS_RESET: begin
        // Reset vector outranks all; fuse is sampled after release
        st_next.pc_load = 1'b1;
        st_next.pc_val = lock.boot_reset_vector_fuse ? BOOT_START :
          APP_START;
        st_next.fsm = CIS_IDLE;
      end
      CIS_IDLE: begin
        if (sp_wr) begin
          st_next.sp = sp_wdata;
        end
        if (status_wr) begin
          st_next.gie = status_wdata[GIE_BIT];
        end
        if (core.boundary && core.op_sei) begin
          st_next.gie = 1'b1;
        end
        if (core.boundary && core.op_cli) begin
          st_next.gie = 1'b0;
        end
        if (start_ret) begin
          st_next.fsm = CIS_RETURN;
          st_next.hold = 1'b1;
          st_next.cnt = '0;
        end else if (take) begin
          st_next.fsm = CIS_ENTRY;
          st_next.gie = 1'b0;
          st_next.hold = 1'b1;
          st_next.cnt = '0;
          st_next.last = core.sleeping ?
            ENTRY_CYC + SLEEP_EXTRA - 4'h1 :
            ENTRY_CYC - 4'h1;
          st_next.ret_pc = core.next_pc;
          st_next.vec = vec_addr;
          st_next.serve = 1'b1;
          st_next.idx = win_idx;
        end
      end
      CIS_ENTRY: begin
        st_next.cnt = st_reg.cnt + 4'h1;
        // Low byte first at the top, high byte below it
        if (st_reg.cnt == 4'h0) begin
          st_next.stk.wr_en = 1'b1;
          st_next.stk.addr = st_reg.sp;
          st_next.stk.wdata = st_reg.ret_pc[BYTE_W-1:0];
        end
        if (st_reg.cnt == 4'h1) begin
          st_next.stk.wr_en = 1'b1;
          st_next.stk.addr = st_reg.sp - 16'h0001;
          st_next.stk.wdata = {3'h0, st_reg.ret_pc[PC_W-1:BYTE_W]};
          st_next.sp = st_reg.sp - SP_STEP;
        end
        if (st_reg.cnt == st_reg.last) begin
          st_next.hold = 1'b0;
          st_next.pc_load = 1'b1;
          st_next.pc_val = st_reg.vec;
          st_next.fsm = CIS_IDLE;
        end
      end
      CIS_RETURN: begin
        st_next.cnt = st_reg.cnt + 4'h1;
        // Read data arrives one cycle after the read strobe
        if (st_reg.cnt == 4'h0) begin
          st_next.stk.rd_en = 1'b1;
          st_next.stk.addr = st_reg.sp + 16'h0001;
        end
        if (st_reg.cnt == 4'h1) begin
          st_next.stk.rd_en = 1'b1;
          st_next.stk.addr = st_reg.sp + SP_STEP;
        end
        if (st_reg.cnt == 4'h2) begin
          st_next.ret_pc[PC_W-1:BYTE_W] = stk_rdata[PC_W-BYTE_W-1:0];
        end
        if (st_reg.cnt == 4'h3) begin
          st_next.ret_pc[BYTE_W-1:0] = stk_rdata;
        end
        if (st_reg.cnt == RETURN_CYC - 4'h1) begin
          st_next.hold = 1'b0;
          st_next.pc_load = 1'b1;
          st_next.pc_val = {st_reg.ret_pc[PC_W-1:BYTE_W], stk_rdata};
          st_next.sp = st_reg.sp + SP_STEP;
          st_next.gie = 1'b1;
          st_next.fsm = CIS_IDLE;
        end
      end
    endcase
  end

  // Status byte other than bit 7 is left to handler software
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.fsm <= CIS_RESET;
      st_reg.sp <= SP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign stk = st_reg.stk;
  assign core_hold = st_reg.hold;
  assign pc_load = st_reg.pc_load;
  assign pc_value = st_reg.pc_val;
  assign global_enable = st_reg.gie;
  assign sp_value = st_reg.sp;
  assign serve_pulse = st_reg.serve;
  assign serve_idx = st_reg.idx;

  // Checks next to the logic they guard
  chk_take_enabled: assert property (
    @(posedge clk_sys) disable iff (srst)
    take |-> (st_reg.gie && irq_enable[win_idx]))
    else $error("interrupt taken while disabled");

  chk_entry_gie: assert property (
    @(posedge clk_sys) disable iff (srst)
    take |=> !global_enable [*4])
    else $error("global enable not cleared on entry");

  chk_cli_now: assert property (
    @(posedge clk_sys) disable iff (srst)
    (core.boundary && core.op_cli) |-> !take ##1 !global_enable)
    else $error("interrupt taken at global disable");

  chk_sei_next: assert property (
    @(posedge clk_sys) disable iff (srst)
    (core.boundary && core.op_sei && st_reg.fsm == CIS_IDLE) |=>
    !serve_pulse)
    else $error("interrupt taken right at global enable");

  chk_only_boundary: assert property (
    @(posedge clk_sys) disable iff (srst)
    serve_pulse |-> ($past(core.boundary) && !$past(core_hold)))
    else $error("interrupt taken mid instruction");

  chk_entry_len: assert property (
    @(posedge clk_sys) disable iff (srst)
    (take && !core.sleeping) |=> core_hold [*4] ##1
    (!core_hold && pc_load))
    else $error("entry not four cycles");

  chk_sleep_len: assert property (
    @(posedge clk_sys) disable iff (srst)
    (take && core.sleeping) |=> core_hold [*8] ##1
    (!core_hold && pc_load))
    else $error("wake entry not eight cycles");

  chk_vector_addr: assert property (
    @(posedge clk_sys) disable iff (srst)
    (take && !core.sleeping) |-> ##5 pc_value == $past(vec_addr, 5))
    else $error("wrong vector address");

  chk_push_sp: assert property (
    @(posedge clk_sys) disable iff (srst)
    take |-> ##5 sp_value == $past(sp_value, 5) - SP_STEP)
    else $error("stack pointer not lowered by two");

  chk_return_seq: assert property (
    @(posedge clk_sys) disable iff (srst)
    start_ret |=> core_hold [*4] ##1
    (pc_load && global_enable && sp_value == $past(sp_value, 5) +
     SP_STEP))
    else $error("return sequence wrong");

  chk_reset_vec: assert property (
    @(posedge clk_sys) disable iff (srst)
    (st_reg.fsm == CIS_RESET && lock.boot_reset_vector_fuse) |=>
    (pc_load && pc_value == BOOT_START))
    else $error("reset vector not relocated");

  chk_reset_app: assert property (
    @(posedge clk_sys) disable iff (srst)
    (st_reg.fsm == CIS_RESET && !lock.boot_reset_vector_fuse) |=>
    (pc_load && pc_value == APP_START))
    else $error("reset vector not at table start");

  chk_table_boot: assert property (
    @(posedge clk_sys) disable iff (srst)
    (take && !core.sleeping && lock.vector_table_select) |->
    ##5 (pc_value > BOOT_START))
    else $error("vector table not relocated");

  chk_flag_hw_clr: assert property (
    @(posedge clk_sys) disable iff (srst)
    (take && win_idx < 3'h4 && !flag_event[win_idx[1:0]]) |=>
    !flags[serve_idx[1:0]])
    else $error("served flag not cleared");

  chk_flag_wr_clr: assert property (
    @(posedge clk_sys) disable iff (srst)
    (flag_clear_wr && flag_clear_data[0] && !flag_event[0]) |=>
    !flags[0])
    else $error("flag not cleared by write of one");

  chk_flag_keep: assert property (
    @(posedge clk_sys) disable iff (srst)
    (flags[0] && !(flag_clear_wr && flag_clear_data[0]) &&
     !(take && win_idx == 3'h0)) |=> flags[0])
    else $error("pending flag lost");

  chk_flag_set: assert property (
    @(posedge clk_sys) disable iff (srst)
    flag_event[0] |=> flags[0])
    else $error("flag event lost to a clear");

  chk_level_gone: assert property (
    @(posedge clk_sys) disable iff (srst)
    (take && !(level_req[0] && irq_enable[4])) |->
    win_idx != 3'h4)
    else $error("vanished level request taken");

  chk_gie_write: assert property (
    @(posedge clk_sys) disable iff (srst)
    (st_reg.fsm == CIS_IDLE && status_wr && !core.boundary) |=>
    global_enable == $past(status_wdata[GIE_BIT]))
    else $error("status write missed global enable");

  chk_lock_mute: assert property (
    @(posedge clk_sys) disable iff (srst)
    ((lock.app_section_lock_bit && lock.vector_table_select &&
      core.next_pc < BOOT_START) ||
     (lock.boot_section_lock_bit && !lock.vector_table_select &&
      core.next_pc >= BOOT_START)) |-> !take)
    else $error("interrupt taken while boot lock mutes it");

  chk_push_bytes: assert property (
    @(posedge clk_sys) disable iff (srst)
    take |-> ##2 (stk.wr_en && stk.addr == $past(sp_value, 2)) ##1
    (stk.wr_en && stk.addr == $past(sp_value, 3) - 16'h0001))
    else $error("return address not pushed");

  chk_pop_reads: assert property (
    @(posedge clk_sys) disable iff (srst)
    start_ret |-> ##2 (stk.rd_en && stk.addr == sp_value + 16'h0001)
    ##1 (stk.rd_en && stk.addr == sp_value + SP_STEP))
    else $error("return address not popped");
endmodule

// [rtl/cis_pkg.sv]
// Shared constants and types of the CPU interrupt sequencer
package cis_pkg;
  // Source counts: flag-type sources take the low indices
  localparam int N_FLAG = 4;
  localparam int N_LVL = 2;
  localparam int N_SRC = N_FLAG + N_LVL;
  localparam int IDX_W = 3;
  localparam int PC_W = 13;
  localparam int SP_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 4;
  // Vector table layout in program words
  localparam logic [PC_W-1:0] APP_START = 13'h0000;
  localparam logic [PC_W-1:0] BOOT_START = 13'h1C00;
  localparam logic [PC_W-1:0] VEC_STRIDE = 13'h0002;
  // Cycle counts of entry and return
  localparam logic [CNT_W-1:0] ENTRY_CYC = 4'h4;
  localparam logic [CNT_W-1:0] SLEEP_EXTRA = 4'h4;
  localparam logic [CNT_W-1:0] RETURN_CYC = 4'h4;
  // Status byte and stack pointer
  localparam int GIE_BIT = 7;
  localparam logic [SP_W-1:0] SP_RST = 16'h0000;
  localparam logic [SP_W-1:0] SP_STEP = 16'h0002;

  typedef enum logic [1:0] {
    CIS_RESET,
    CIS_IDLE,
    CIS_ENTRY,
    CIS_RETURN
  } cis_state_t;

  // Instruction boundary report from the execution core
  typedef struct packed {
    logic boundary;
    logic op_sei;
    logic op_cli;
    logic op_return;
    logic sleeping;
    logic [PC_W-1:0] next_pc;
  } cis_core_t;

  // Byte-wide stack access towards data memory
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [SP_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } cis_stack_t;

  // Vector placement and boot lock configuration
  typedef struct packed {
    logic vector_table_select;
    logic boot_reset_vector_fuse;
    logic app_section_lock_bit;
    logic boot_section_lock_bit;
  } cis_lock_t;
endpackage

// [rtl/cis_flag_bank.sv]
// Latched interrupt flags of the flag-type sources
`timescale 1ns/1ps
module cis_flag_bank (
  input wire logic clk_sys, // Core clock
  input wire logic srst, // Synchronous reset
  input wire logic [cis_pkg::N_FLAG-1:0] event_in, // Source events
  input wire logic clr_wr, // Software flag write
  input wire logic [cis_pkg::N_FLAG-1:0] clr_data, // Ones clear
  input wire logic hw_ack, // Vectored to any source, flag or level
  input wire logic [cis_pkg::IDX_W-1:0] hw_idx, // Source being served
  output logic [cis_pkg::N_FLAG-1:0] flags // Latched flags
);
  import cis_pkg::*;

  typedef struct packed {
    logic [N_FLAG-1:0] flag;
  } cis_flag_st_t;

  cis_flag_st_t st_reg;
  cis_flag_st_t st_next;

  // Per flag: a new event beats any clear in the same cycle
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < N_FLAG; i++) begin
      if (clr_wr && clr_data[i]) begin
        st_next.flag[i] = 1'b0;
      end
      if (hw_ack && hw_idx == i[IDX_W-1:0]) begin
        st_next.flag[i] = 1'b0;
      end
      if (event_in[i]) begin
        st_next.flag[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags = st_reg.flag;
endmodule

// [rtl/cis_arbiter.sv]
// Fixed-priority selection among enabled pending requests
`timescale 1ns/1ps
module cis_arbiter (
  input wire logic [cis_pkg::N_FLAG-1:0] flags, // Latched flags
  input wire logic [cis_pkg::N_LVL-1:0] level_req, // Level requests
  input wire logic [cis_pkg::N_SRC-1:0] enables, // Individual enables
  input wire logic [cis_pkg::PC_W-1:0] pc, // Current program counter
  input wire cis_pkg::cis_lock_t lock, // Vector and lock setup
  output logic win_valid, // Some request may be taken
  output logic [cis_pkg::IDX_W-1:0] win_idx // Winning source index
);
  import cis_pkg::*;

  logic [N_SRC-1:0] req;
  logic pc_in_boot;
  logic suppress;

  // Level sources are not latched, so a vanished condition is no request
  assign req = {level_req, flags} & enables;

  // Boot locks mute interrupts whose table lies in the other section
  assign pc_in_boot = (pc >= BOOT_START);
  assign suppress =
    (lock.app_section_lock_bit && !pc_in_boot &&
     lock.vector_table_select) ||
    (lock.boot_section_lock_bit && pc_in_boot &&
     !lock.vector_table_select);

  // Lowest index, hence lowest vector address, wins
  always_comb begin
    win_valid = 1'b0;
    win_idx = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        win_valid = !suppress;
        win_idx = i[IDX_W-1:0];
      end
    end
  end
endmodule

// [sim/cis_stack_mem.sv]
// Stack memory model standing at the far side of the sequencer
`timescale 1ns/1ps
module cis_stack_mem (
  input wire logic clk_sys, // Core clock
  input wire cis_pkg::cis_stack_t stk, // Stack access
  output logic [cis_pkg::BYTE_W-1:0] stk_rdata // Read data
);
  import cis_pkg::*;
  logic [BYTE_W-1:0] mem [0:255];
  initial stk_rdata = 8'h00;
  // Data is valid one cycle after a read; toggles otherwise so stale
  // bytes are never mistaken for a good pop
  always @(posedge clk_sys) begin
    if (stk.wr_en) mem[stk.addr[7:0]] <= stk.wdata;
    if (stk.rd_en) stk_rdata <= mem[stk.addr[7:0]];
    else stk_rdata <= ~stk_rdata;
  end
endmodule

// [sim/tb_top.sv]
// Self-checking bench of the interrupt sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
  import cis_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  cis_core_t core = '0;
  cis_lock_t lock = '0;
  logic [N_FLAG-1:0] flag_event = '0, flag_clear_data = '0, flags;
  logic flag_clear_wr = 1'b0, status_wr = 1'b0, sp_wr = 1'b0;
  logic [N_LVL-1:0] level_req = '0;
  logic [N_SRC-1:0] irq_enable = '0;
  logic [BYTE_W-1:0] status_wdata = '0, stk_rdata;
  logic [SP_W-1:0] sp_wdata = '0, sp_value;
  cis_stack_t stk;
  logic core_hold, pc_load, global_enable, serve_pulse;
  logic [PC_W-1:0] pc_value, npc;
  logic [IDX_W-1:0] serve_idx;
  logic [3:0] m;
  int num_errors = 0, compares = 0;
  always #2.5 clk_sys = ~clk_sys;
  cis_sequencer DUT (.clk_sys(clk_sys), .srst(srst), .core(core),
    .lock(lock), .flag_event(flag_event), .flag_clear_wr(flag_clear_wr),
    .flag_clear_data(flag_clear_data), .level_req(level_req),
    .irq_enable(irq_enable), .status_wr(status_wr),
    .status_wdata(status_wdata), .sp_wr(sp_wr), .sp_wdata(sp_wdata),
    .stk_rdata(stk_rdata), .stk(stk), .core_hold(core_hold),
    .pc_load(pc_load), .pc_value(pc_value), .global_enable(global_enable),
    .sp_value(sp_value), .serve_pulse(serve_pulse), .serve_idx(serve_idx),
    .flags(flags));
  cis_stack_mem u_stk (.clk_sys(clk_sys), .stk(stk), .stk_rdata(stk_rdata));
  function automatic logic [PC_W-1:0] vec(input logic [PC_W-1:0] base,
      input logic [IDX_W-1:0] i);
    return base + VEC_STRIDE * ({10'h000, i} + 13'h0001);
  endfunction
  function automatic logic [IDX_W-1:0] lowest(input logic [3:0] f);
    lowest = 3'h0;
    for (int i = 3; i >= 0; i--) if (f[i]) lowest = 3'(i);
  endfunction
  task automatic give_verdict();
    $display("Compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One instruction boundary; returns just after the answer edge
  task automatic bnd(input int kind, input logic [PC_W-1:0] pc);
    @(negedge clk_sys);
    core.boundary = 1'b1;
    core.op_sei = (kind == 1);
    core.op_cli = (kind == 2);
    core.op_return = (kind == 3);
    core.next_pc = pc;
    @(negedge clk_sys);
    core = '{sleeping: core.sleeping, next_pc: pc, default: 1'b0};
  endtask
  task automatic wait_load(input int n_exp, input logic [PC_W-1:0] pc);
    int n;
    n = 1;
    while (pc_load !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(n, n_exp)
    `CHK(pc_value, pc)
  endtask
  task automatic take(input logic [IDX_W-1:0] i, input logic [PC_W-1:0] pc,
      input logic [PC_W-1:0] base);
    logic [SP_W-1:0] sp0;
    sp0 = sp_value;
    bnd(0, pc);
    `CHK(serve_pulse, 1'b1)
    `CHK(serve_idx, i)
    `CHK(core_hold, 1'b1)
    if (i < 3'h4) `CHK(flags[i[1:0]], 1'b0)
    wait_load(core.sleeping ? 9 : 5, vec(base, i));
    `CHK(global_enable, 1'b0)
    `CHK(sp_value, sp0 - SP_STEP)
    `CHK(u_stk.mem[sp0[7:0]], pc[7:0])
    `CHK(u_stk.mem[sp0[7:0] - 8'h01], {3'h0, pc[12:8]})
  endtask
  task automatic no_take(input int kind, input logic [PC_W-1:0] pc);
    bnd(kind, pc);
    `CHK({serve_pulse, core_hold}, 2'b00)
  endtask
  task automatic ret(input logic [PC_W-1:0] pc);
    logic [SP_W-1:0] sp0;
    sp0 = sp_value;
    bnd(3, 13'($urandom));
    wait_load(5, pc);
    `CHK(global_enable, 1'b1)
    `CHK(sp_value, sp0 + SP_STEP)
  endtask
  task automatic pulse(input int kind, input logic [7:0] d);
    @(negedge clk_sys);
    if (kind == 0) flag_event = d[3:0];
    if (kind == 1) {flag_clear_wr, flag_clear_data} = {1'b1, d[3:0]};
    if (kind == 2) {status_wr, status_wdata} = {1'b1, d};
    @(negedge clk_sys);
    {flag_event, flag_clear_wr, status_wr} = '0;
    @(negedge clk_sys);
  endtask
  task automatic do_reset(input logic fuse);
    int n;
    n = 0;
    srst = 1'b1;
    lock.boot_reset_vector_fuse = fuse;
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
    while (pc_load !== 1'b1 && n < 10) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(pc_value, fuse ? BOOT_START : APP_START)
    `CHK(n, 1)
    lock = '0;
  endtask
  // Watchdog: the whole run needs a few hundred cycles
  initial begin
    #100000;
    num_errors++;
    $display("Error at %0t: got %h expected %h", $time, 0, 1);
    give_verdict();
  end
  initial begin
    void'($urandom(32'h1BCB));
    do_reset(1'b1);
    do_reset(1'b0);
    @(negedge clk_sys);
    {sp_wr, sp_wdata} = {1'b1, 16'h0080 + 16'($urandom_range(112, 16))};
    @(negedge clk_sys);
    sp_wr = 1'b0;
    irq_enable = 6'h3F;
    pulse(2, 8'h80);
    `CHK(global_enable, 1'b1)
    $display("Test reset done");
    // Random flag sets drained in priority order
    for (int r = 0; r < 8; r++) begin
      m = 4'($urandom_range(15, 1));
      pulse(0, {4'h0, m});
      while (flags !== 4'h0) begin
        npc = 13'($urandom);
        take(lowest(flags), npc, APP_START);
        ret(npc);
      end
    end
    $display("Test priority done");
    pulse(2, 8'h00);
    pulse(0, 8'h0F);
    pulse(1, 8'h05);
    `CHK(flags, 4'hA)
    pulse(1, 8'h0A);
    irq_enable = 6'h00;
    pulse(2, 8'h80);
    pulse(0, 8'h06);
    no_take(0, 13'h0100);
    `CHK(flags, 4'h6)
    irq_enable = 6'h3F;
    pulse(2, 8'h00);
    no_take(0, 13'h0100);
    no_take(1, 13'h0100);
    no_take(1, 13'h0100);
    take(3'h1, 13'h0101, APP_START);
    ret(13'h0101);
    take(3'h2, 13'h0102, APP_START);
    ret(13'h0102);
    $display("Test enables done");
    pulse(0, 8'h01);
    no_take(2, 13'h0200);
    `CHK(global_enable, 1'b0)
    pulse(2, 8'h80);
    take(3'h0, 13'h0200, APP_START);
    // Handler re-enables; it owns the status byte save
    pulse(2, 8'h80);
    pulse(0, 8'h08);
    take(3'h3, 13'h0010, APP_START);
    ret(13'h0010);
    pulse(0, 8'h02);
    ret(13'h0200);
    repeat (3) @(negedge clk_sys);
    `CHK(core_hold, 1'b0)
    take(3'h1, 13'h0201, APP_START);
    ret(13'h0201);
    $display("Test nesting done");
    irq_enable[4] = 1'b0;
    level_req = 2'b01;
    repeat (3) @(negedge clk_sys);
    level_req = 2'b00;
    irq_enable = 6'h3F;
    no_take(0, 13'h0300);
    level_req = 2'b10;
    take(3'h5, 13'h0300, APP_START);
    level_req = 2'b00;
    ret(13'h0300);
    core.sleeping = 1'b1;
    pulse(0, 8'h01);
    take(3'h0, 13'h0301, APP_START);
    core.sleeping = 1'b0;
    ret(13'h0301);
    $display("Test level and sleep done");
    lock.vector_table_select = 1'b1;
    pulse(0, 8'h01);
    take(3'h0, 13'h1D00, BOOT_START);
    ret(13'h1D00);
    lock.app_section_lock_bit = 1'b1;
    pulse(0, 8'h01);
    no_take(0, 13'h0100);
    take(3'h0, 13'h1D10, BOOT_START);
    ret(13'h1D10);
    lock = '{boot_section_lock_bit: 1'b1, default: 1'b0};
    pulse(0, 8'h01);
    no_take(0, 13'h1D20);
    $display("Test vectors and locks done");
    give_verdict();
  end
endmodule
